// ==== rtl/aer_device.sv ====
`timescale 1ns/1ps
`include "aer_defines.svh"
// How it works
// - ext select: read state set by select lines
// - read shifts out last completed result
// - bit changes on rising edge, holds across falling edge
// - host clocks only while reading, apart from one sync arming edge
// - no clock in late conversion half
// - reads during sampling finish before converting
// - idle-time clock edge arms a sync pulse
// - first rising edge gives sync, bits follow
// - with sync: 17 or 18 pulses
// - no idle edges: first edge gives msb
// - without sync: 16 or 17 pulses
// - chain input passes through to data
// - cascades use external clock only
// - cascade reads fit in sampling period
// - read end leaves data at held chain level
// - held chain level separates chained words
// - conversion starts when both selects low
// - busy low while converting, high when stored
// - sixteen bits, msb first
// - format pin picks binary or twos complement
module aer_device #(
  parameter int WORD_BITS = `AER_WORD_BITS,
  parameter int CONV_CYCLES = `AER_CONV_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  aer_link_if.dev link,
  input wire logic [WORD_BITS-1:0] sample_in,
  input wire logic chain_in,
  input wire logic output_format_select_in,
  output logic [WORD_BITS-1:0] last_result_out,
  output logic in_read_out
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic cs_n_m, cs_n_s;
  logic rc_m, rc_s;
  logic ext_m, ext_s;
  logic sclk_m, sclk_s, sclk_d;
  logic chain_m, chain_s;
  logic fmt_m, fmt_s;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cs_n_m <= 1'b1;
      cs_n_s <= 1'b1;
      rc_m <= 1'b1;
      rc_s <= 1'b1;
      ext_m <= 1'b1;
      ext_s <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      chain_m <= 1'b0;
      chain_s <= 1'b0;
      fmt_m <= 1'b1;
      fmt_s <= 1'b1;
    end else if (ce_in) begin
      // the shift clock is not related to our clock, so every pin gets two stages
      cs_n_m <= link.cs_n;
      cs_n_s <= cs_n_m;
      rc_m <= link.conv_read;
      rc_s <= rc_m;
      ext_m <= link.clk_src_sel;
      ext_s <= ext_m;
      sclk_m <= link.serial_shift_clock;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      chain_m <= chain_in;
      chain_s <= chain_m;
      fmt_m <= output_format_select_in;
      fmt_s <= fmt_m;
    end
  end

  // --------------------------------------------------------------------------
  // decoded link conditions
  // --------------------------------------------------------------------------
  logic sclk_rise;
  logic conv_req_n, conv_req_n_d;
  logic conv_start;
  logic read_now;

  assign sclk_rise = sclk_s & ~sclk_d;
  // the two selects are combined: the later of the two falling edges starts it
  assign conv_req_n = cs_n_s | rc_s;
  assign conv_start = conv_req_n_d & ~conv_req_n;
  assign read_now = ext_s & ~cs_n_s & rc_s;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      conv_req_n_d <= 1'b1;
    end else if (ce_in) begin
      conv_req_n_d <= conv_req_n;
    end
  end

  // --------------------------------------------------------------------------
  // conversion timing and busy
  // --------------------------------------------------------------------------
  aer_pkg::aer_conv_state_t conv_state;
  logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt;
  logic [WORD_BITS-1:0] held_sample;
  logic [WORD_BITS-1:0] out_word;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      conv_state <= aer_pkg::AER_CV_IDLE;
      conv_cnt <= '0;
      held_sample <= '0;
    end else if (ce_in) begin
      case (conv_state)
        aer_pkg::AER_CV_IDLE: begin
          if (conv_start) begin
            conv_state <= aer_pkg::AER_CV_RUN;
            conv_cnt <= '0;
            held_sample <= sample_in;
          end
        end
        aer_pkg::AER_CV_RUN: begin
          if (conv_cnt == CONV_CYCLES[$bits(conv_cnt)-1:0] - 1'b1) begin
            conv_state <= aer_pkg::AER_CV_IDLE;
          end else begin
            conv_cnt <= conv_cnt + 1'b1;
          end
        end
        default: begin
          conv_state <= aer_pkg::AER_CV_IDLE;
        end
      endcase
    end
  end

  // busy rises in the same cycle that the result reaches the output register
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      out_word <= '0;
      link.busy <= 1'b1;
    end else if (ce_in) begin
      if (conv_state == aer_pkg::AER_CV_IDLE && conv_start) begin
        link.busy <= 1'b0;
      end else if (conv_state == aer_pkg::AER_CV_RUN &&
                   conv_cnt == CONV_CYCLES[$bits(conv_cnt)-1:0] - 1'b1) begin
        link.busy <= 1'b1;
        out_word <= held_sample;
      end
    end
  end

  assign last_result_out = out_word;

  // --------------------------------------------------------------------------
  // read state and sync tracking
  // --------------------------------------------------------------------------
  logic in_read;
  logic sync_armed;
  logic held_chain;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      in_read <= 1'b0;
      held_chain <= 1'b0;
    end else if (ce_in) begin
      in_read <= read_now;
      if (read_now && !in_read) begin
        held_chain <= chain_s;
      end
    end
  end

  assign in_read_out = in_read;

  // an edge seen outside a read arms the sync; arming wins over the clear
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sync_armed <= 1'b0;
    end else if (ce_in) begin
      if (sclk_rise && !in_read) begin
        sync_armed <= 1'b1;
      end else if (sclk_rise && in_read && sync_armed) begin
        sync_armed <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // serial shifter
  // --------------------------------------------------------------------------
  // one extra stage carries the chain level so a cascade sees a separator bit
  logic [WORD_BITS:0] shreg;

  function automatic logic [WORD_BITS-1:0] fmt_word(input logic [WORD_BITS-1:0] w,
                                                    input logic straight);
    fmt_word = straight ? w : {~w[WORD_BITS-1], w[WORD_BITS-2:0]};
  endfunction

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      shreg <= '0;
      link.data <= 1'b0;
      link.sync <= 1'b0;
    end else if (ce_in) begin
      if (read_now && !in_read) begin
        // result of the last finished conversion, even mid-conversion
        shreg <= {fmt_word(out_word, fmt_s), chain_s};
        link.sync <= 1'b0;
      end else if (in_read && sclk_rise) begin
        if (sync_armed) begin
          link.sync <= 1'b1;
        end else begin
          // output changes only on rising edges, so it holds through the falling one
          link.sync <= 1'b0;
          link.data <= shreg[WORD_BITS];
          shreg <= {shreg[WORD_BITS-1:0], chain_s};
        end
      end else if (!read_now && in_read) begin
        link.data <= held_chain;
        link.sync <= 1'b0;
      end
    end
  end

endmodule

// ==== include/aer_defines.svh ====
`ifndef AER_DEFINES_SVH
`define AER_DEFINES_SVH

// ----------------------------------------------------------------------------
// link and clock figures
// ----------------------------------------------------------------------------
`define AER_CLK_MHZ 40
`define AER_WORD_BITS 16
`define AER_CONV_NS 2200
`define AER_CONV_CYCLES ((`AER_CONV_NS * `AER_CLK_MHZ) / 1000)
`define AER_CONV_PULSE_NS 40
`define AER_CONV_PULSE_CYCLES ((`AER_CONV_PULSE_NS * `AER_CLK_MHZ + 999) / 1000)
`define AER_SHIFT_HALF_CYCLES 8
`define AER_SYNC_EXTRA 1

// ----------------------------------------------------------------------------
// controller register map (word addresses, word index on the bus)
// ----------------------------------------------------------------------------
`define AER_REG_CTRL 2'h0
`define AER_REG_STATUS 2'h1
`define AER_REG_DATA 2'h2
`define AER_CTRL_CONVERT 0
`define AER_CTRL_READ 1
`define AER_CTRL_SYNC 2
`define AER_CTRL_EXT 3
`define AER_STAT_ENGINE 0
`define AER_STAT_BUSY 1
`define AER_STAT_READY 2
`define AER_CTRL_RESET 4'h8

`endif

// ==== include/aer_pkg.sv ====
package aer_pkg;
  typedef enum logic [1:0] {
    AER_CV_IDLE,
    AER_CV_RUN
  } aer_conv_state_t;

  typedef enum logic [2:0] {
    AER_H_IDLE,
    AER_H_CONV,
    AER_H_RSETUP,
    AER_H_HIGH,
    AER_H_LOW,
    AER_H_DONE
  } aer_host_state_t;
endpackage

// ==== include/aer_link_if.sv ====
`timescale 1ns/1ps
interface aer_link_if;
  logic cs_n;
  logic conv_read;
  logic clk_src_sel;
  logic serial_shift_clock;
  logic busy;
  logic data;
  logic sync;

  modport dev (
    input cs_n,
    input conv_read,
    input clk_src_sel,
    input serial_shift_clock,
    output busy,
    output data,
    output sync
  );

  modport host (
    output cs_n,
    output conv_read,
    output clk_src_sel,
    output serial_shift_clock,
    input busy,
    input data,
    input sync
  );
endinterface

// ==== rtl/aer_host.sv ====
`timescale 1ns/1ps
`include "aer_defines.svh"
module aer_host #(
  parameter int WORD_BITS = `AER_WORD_BITS,
  parameter int HALF_CYCLES = `AER_SHIFT_HALF_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  aer_link_if.host link,
  input wire logic [1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  // --------------------------------------------------------------------------
  // converter pins in
  // --------------------------------------------------------------------------
  logic busy_m, busy_s;
  logic data_m, data_s;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      busy_m <= 1'b1;
      busy_s <= 1'b1;
      data_m <= 1'b0;
      data_s <= 1'b0;
    end else if (ce_in) begin
      busy_m <= link.busy;
      busy_s <= busy_m;
      data_m <= link.data;
      data_s <= data_m;
    end
  end

  // --------------------------------------------------------------------------
  // register slave
  // --------------------------------------------------------------------------
  aer_pkg::aer_host_state_t state;
  logic ack;
  logic [3:0] ctrl;
  logic word_ready;
  logic [WORD_BITS:0] capture;
  logic wr_ctrl;

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign wr_ctrl = avs_write_in & ack & (avs_address_in == `AER_REG_CTRL);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ack <= 1'b0;
      avs_readdata_out <= '0;
    end else if (ce_in) begin
      ack <= (avs_read_in | avs_write_in) & ~ack;
      if (avs_read_in && !ack) begin
        case (avs_address_in)
          `AER_REG_CTRL: avs_readdata_out <= {28'h0, ctrl};
          `AER_REG_STATUS: avs_readdata_out <= {29'h0, word_ready, ~busy_s,
                                                state != aer_pkg::AER_H_IDLE};
          `AER_REG_DATA: avs_readdata_out <= {16'h0, capture[WORD_BITS-1:0]};
          default: avs_readdata_out <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ctrl <= `AER_CTRL_RESET;
    end else if (ce_in && wr_ctrl && state == aer_pkg::AER_H_IDLE) begin
      ctrl <= {avs_writedata_in[`AER_CTRL_EXT], avs_writedata_in[`AER_CTRL_SYNC], 2'h0};
    end
  end

  // --------------------------------------------------------------------------
  // conversion and read sequencer
  // --------------------------------------------------------------------------
  logic [7:0] tmr;
  logic [5:0] pulses;
  logic [5:0] pulse_total;
  logic arm_pulse;

  // with a sync pulse one more clock is needed ahead of the msb
  assign pulse_total = 6'(WORD_BITS) + (ctrl[`AER_CTRL_SYNC] ? 6'(`AER_SYNC_EXTRA) : 6'h0);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state <= aer_pkg::AER_H_IDLE;
      tmr <= '0;
      pulses <= '0;
      capture <= '0;
      word_ready <= 1'b0;
      arm_pulse <= 1'b0;
      link.cs_n <= 1'b1;
      link.conv_read <= 1'b1;
      link.serial_shift_clock <= 1'b0;
      link.clk_src_sel <= 1'b1;
    end else if (ce_in) begin
      link.clk_src_sel <= ctrl[`AER_CTRL_EXT];
      case (state)
        aer_pkg::AER_H_IDLE: begin
          tmr <= '0;
          pulses <= '0;
          // a read starts only while busy_s is high; a request made while it is low is dropped, not held
          if (wr_ctrl && avs_writedata_in[`AER_CTRL_CONVERT]) begin
            link.cs_n <= 1'b0;
            link.conv_read <= 1'b0;
            state <= aer_pkg::AER_H_CONV;
          end else if (wr_ctrl && avs_writedata_in[`AER_CTRL_READ] && busy_s) begin
            link.conv_read <= 1'b1;
            word_ready <= 1'b0;
            if (avs_writedata_in[`AER_CTRL_SYNC]) begin
              // one edge while deselected arms the sync; it falls before the select
              link.serial_shift_clock <= 1'b1;
              arm_pulse <= 1'b1;
            end else begin
              link.cs_n <= 1'b0;
            end
            state <= aer_pkg::AER_H_RSETUP;
          end
        end
        aer_pkg::AER_H_CONV: begin
          tmr <= tmr + 1'b1;
          if (tmr == 8'(`AER_CONV_PULSE_CYCLES - 1)) begin
            link.cs_n <= 1'b1;
            link.conv_read <= 1'b1;
            state <= aer_pkg::AER_H_IDLE;
          end
        end
        aer_pkg::AER_H_RSETUP: begin
          tmr <= tmr + 1'b1;
          if (!arm_pulse) begin
            link.cs_n <= 1'b0;
          end
          if (tmr == 8'(HALF_CYCLES - 1)) begin
            tmr <= '0;
            if (arm_pulse) begin
              arm_pulse <= 1'b0;
              link.serial_shift_clock <= 1'b0;
            end else begin
              link.serial_shift_clock <= 1'b1;
              state <= aer_pkg::AER_H_HIGH;
            end
          end
        end
        aer_pkg::AER_H_HIGH: begin
          tmr <= tmr + 1'b1;
          if (tmr == 8'(HALF_CYCLES - 1)) begin
            // bit is stable since the rising edge; take it before the falling one
            capture <= {capture[WORD_BITS-1:0], data_s};
            tmr <= '0;
            pulses <= pulses + 1'b1;
            link.serial_shift_clock <= 1'b0;
            state <= aer_pkg::AER_H_LOW;
          end
        end
        aer_pkg::AER_H_LOW: begin
          tmr <= tmr + 1'b1;
          if (tmr == 8'(HALF_CYCLES - 1)) begin
            tmr <= '0;
            if (pulses == pulse_total) begin
              link.cs_n <= 1'b1;
              state <= aer_pkg::AER_H_DONE;
            end else begin
              link.serial_shift_clock <= 1'b1;
              state <= aer_pkg::AER_H_HIGH;
            end
          end
        end
        aer_pkg::AER_H_DONE: begin
          word_ready <= 1'b1;
          state <= aer_pkg::AER_H_IDLE;
        end
        default: begin
          state <= aer_pkg::AER_H_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== test/aer_link_properties.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// link checks, both ends are design code
// ----------------------------------------
module aer_link_properties (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n,
  input wire logic conv_read,
  input wire logic clk_src_sel,
  input wire logic serial_shift_clock,
  input wire logic busy,
  input wire logic data,
  input wire logic sync
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_busy_start: assert property ($fell(cs_n | conv_read) |-> ##[1:8] !busy)
    else $error("busy did not fall after convert start");
  a_busy_return: assert property ($fell(busy) |-> ##[1:200] busy)
    else $error("busy stuck low");
  a_no_clk_busy: assert property (!busy |-> !$rose(serial_shift_clock))
    else $error("shift clock edge during conversion");
  a_read_idle: assert property ((!cs_n && conv_read) |-> busy)
    else $error("read overlaps conversion");
  a_ext_select: assert property (!cs_n |-> clk_src_sel)
    else $error("internal clock selected while selected");
  a_convert_pulse: assert property ($fell(conv_read) |-> !cs_n ##1 !conv_read)
    else $error("convert pulse too short");
  a_sync_read: assert property ($rose(sync) |-> !cs_n && conv_read)
    else $error("sync outside read state");
  a_sync_width: assert property ($rose(sync) |-> sync[*8] ##[1:12] !sync)
    else $error("sync width wrong");
  a_bit_hold: assert property ($fell(serial_shift_clock) |-> $stable(data) ##1 $stable(data))
    else $error("data moved at falling shift edge");
  // a long deselect must leave the data line steady, whatever its level
  a_idle_data: assert property (cs_n[*8] ##1 cs_n[*8] |-> $stable(data))
    else $error("data moved while idle");
endmodule

// ==== test/adc_ext_clock_serial_readout_test.sv ====
`timescale 1ns/1ps
module adc_ext_clock_serial_readout_test;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] av_addr = 2'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [15:0] sample = 16'h0;
  logic chain = 1'b0;
  logic fmt = 1'b1;
  logic [15:0] last_res;
  logic in_read;
  logic sclk_q = 1'b0;
  logic [15:0] wire_word = 16'h0;
  logic sync_seen = 1'b0;
  logic [31:0] q;
  int falls = 0;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #12.5 core_clk_in = ~core_clk_in;

  aer_link_if link ();
  aer_device #(.CONV_CYCLES(10)) u_aer_device (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .ce_in(1'b1), .link(link), .sample_in(sample),
    .chain_in(chain), .output_format_select_in(fmt), .last_result_out(last_res),
    .in_read_out(in_read));
  aer_host u_aer_host (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
    .link(link), .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
    .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait));
  aer_link_properties u_aer_link_properties (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .cs_n(link.cs_n), .conv_read(link.conv_read),
    .clk_src_sel(link.clk_src_sel), .serial_shift_clock(link.serial_shift_clock),
    .busy(link.busy), .data(link.data), .sync(link.sync));

  // ----------------------------------------
  // wire monitor and timeout
  // ----------------------------------------
  // bits are taken at the falling shift edge, where they must be settled
  always @(posedge core_clk_in) begin
    sclk_q <= link.serial_shift_clock;
    if (sclk_q === 1'b1 && link.serial_shift_clock === 1'b0 && link.cs_n === 1'b0) begin
      wire_word <= {wire_word[14:0], link.data};
      falls <= falls + 1;
    end
    if (link.sync === 1'b1)
      sync_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
    av_addr <= a;
    av_wr <= w;
    av_rd <= ~w;
    av_wdata <= d;
    do @(posedge core_clk_in); while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] want);
    do av(2'h1, 1'b0, 32'h0); while ((q & mask) !== want);
  endtask

  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // optional conversion, then one read of the stored result
  task automatic run_case(input logic [15:0] s, input logic f, input logic sy, input logic ch,
                          input logic cv);
    logic [15:0] exp;
    exp = f ? s : (s ^ 16'h8000);
    sample <= s;
    fmt <= f;
    chain <= ch;
    if (cv) begin
      av(2'h0, 1'b1, 32'h9);
      // status bit1 is high while the converter is busy
      wait_stat(32'h2, 32'h2);
      wait_stat(32'h3, 32'h0);
      check({16'h0, last_res}, {16'h0, s});
    end
    falls = 0;
    sync_seen = 1'b0;
    av(2'h0, 1'b1, {28'h0, 1'b1, sy, 2'h2});
    wait_stat(32'h5, 32'h4);
    av(2'h2, 1'b0, 32'h0);
    check(q, {16'h0, exp});
    check({16'h0, wire_word}, {16'h0, exp});
    check(32'(falls), sy ? 32'd17 : 32'd16);
    check({31'h0, sync_seen}, {31'h0, sy});
    check({30'h0, in_read, link.data}, {31'h0, ch});
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    av(2'h1, 1'b0, 32'h0);
    check(q, 32'h0);
    av(2'h0, 1'b0, 32'h0);
    check(q, 32'h8);
    av(2'h3, 1'b1, 32'hffff_ffff);
    av(2'h3, 1'b0, 32'h0);
    check(q, 32'h0);
    run_case(16'ha5c3, 1'b1, 1'b0, 1'b0, 1'b1);
    run_case(16'h0001, 1'b0, 1'b1, 1'b1, 1'b1);
    run_case(16'hffff, 1'b1, 1'b0, 1'b1, 1'b1);
    run_case(16'hffff, 1'b0, 1'b0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
